// *** pkg/beo_pkg.sv ***
// shared types and constants for the bit edge and latch execution unit
package beo_pkg;

  // instance table for edge-pulse history
  localparam int unsigned INST_W       = 6;
  localparam int unsigned INST_N       = 64;

  // operand bit addressing
  localparam int unsigned WORD_W       = 8;
  localparam int unsigned BIT_W        = 4;

  // built-in output words reached by the immediate-refresh variants
  localparam logic [7:0]  OUT_WORD_LO  = 8'h64;
  localparam logic [7:0]  OUT_WORD_HI  = 8'h65;

  // reset value of every stored previous condition
  localparam logic        HIST_RST     = 1'b0;

  // cycles from request to operand write
  localparam int unsigned PIPE_LAT     = 2;

  // instruction opcodes, one-hot
  typedef enum logic [3:0] {
    OP_RISING_EDGE_PULSE  = 4'h1,
    OP_FALLING_EDGE_PULSE = 4'h2,
    OP_BIT_SET_LATCH      = 4'h4,
    OP_BIT_CLEAR_LATCH    = 4'h8
  } beo_op_e;

  // operand data areas
  typedef enum logic [2:0] {
    AREA_IO      = 3'h0,
    AREA_WORK    = 3'h1,
    AREA_HOLD    = 3'h2,
    AREA_AUX     = 3'h3,
    AREA_TIMER   = 3'h4,
    AREA_COUNTER = 3'h5
  } beo_area_e;

  // one instruction evaluation presented by the scan sequencer
  typedef struct packed {
    beo_op_e             op;
    logic                imm;
    beo_area_e           area;
    logic [WORD_W-1:0]   word;
    logic [BIT_W-1:0]    bitn;
    logic [INST_W-1:0]   inst;
    logic                cond;
    logic                ilk_on;
    logic                jumped;
    logic                sub_off;
  } beo_req_s;

  // one operand bit write
  typedef struct packed {
    beo_area_e           area;
    logic [WORD_W-1:0]   word;
    logic [BIT_W-1:0]    bitn;
    logic                val;
  } beo_wr_s;

endpackage

// *** logic/beo_hist_mem.sv ***
// previous-condition memory for edge-pulse instances
`timescale 1ns/1ps
module beo_hist_mem (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_b_i,
  input  wire logic [beo_pkg::INST_W-1:0] rd_addr_i,
  output logic                            rd_data_o,
  input  wire logic                       wr_en_i,
  input  wire logic [beo_pkg::INST_W-1:0] wr_addr_i,
  input  wire logic                       wr_data_i
);

  logic [beo_pkg::INST_N-1:0] mem_q;

  // held in flops so reset can clear every instance at once
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      mem_q <= {beo_pkg::INST_N{beo_pkg::HIST_RST}};
    end else if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  // read during write returns the old value; the caller forwards
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      rd_data_o <= beo_pkg::HIST_RST;
    end else begin
      rd_data_o <= mem_q[rd_addr_i];
    end
  end

endmodule

// *** logic/beo_exec.sv ***
// execution unit for edge-pulse, set and clear bit instructions
`timescale 1ns/1ps
// Overview of operation
// RULE1 - a rising-edge instruction whose condition was OFF last time and is ON now writes its operand ON.
// RULE2 - the next evaluation of that rising-edge instruction writes its operand OFF, giving a one-cycle pulse.
// RULE3 - a falling-edge instruction whose condition was ON last time and is OFF now writes its operand ON.
// RULE4 - the next evaluation of that falling-edge instruction writes its operand OFF again.
// RULE5 - these instructions change no condition or error flag, only the operand bit.
// RULE6 - the set instruction forces its operand to 1 when its condition is ON and leaves it alone otherwise.
// RULE7 - the clear instruction forces its operand to 0 when its condition is ON and leaves it alone otherwise.
// RULE8 - immediate variants aimed at a built-in output also refresh the physical output at execution.
// RULE9 - set and clear inside an active interlock or a jumped section leave the operand unchanged.
// RULE10 - timer and counter operands are refused by the set and clear instructions.
// RULE11 - every set and clear executes on its own, any number may target the same bit.
// RULE12 - the edge result depends on the own condition and on the state of the enclosing section.
// RULE13 - edge instructions in a subroutine that does not run are not evaluated and keep their history.
// RULE14 - the program must not evaluate the same edge instance more than once per scan.
// RULE15 - each edge instance keeps its own previous condition, updated on evaluation and cleared at reset.
module beo_exec (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             req_valid_i,
  input  wire beo_pkg::beo_req_s req_i,
  output logic                  wr_valid_o,
  output beo_pkg::beo_wr_s      wr_o,
  output logic                  refresh_valid_o,
  output beo_pkg::beo_wr_s      refresh_o,
  output logic                  reject_o,
  output logic                  skip_o
);

  function automatic logic is_edge_op(input beo_pkg::beo_op_e op);
    is_edge_op = (op == beo_pkg::OP_RISING_EDGE_PULSE) || (op == beo_pkg::OP_FALLING_EDGE_PULSE);
  endfunction

  function automatic logic is_tc_area(input beo_pkg::beo_area_e area);
    is_tc_area = (area == beo_pkg::AREA_TIMER) || (area == beo_pkg::AREA_COUNTER);
  endfunction

  function automatic logic is_builtin_out(input beo_pkg::beo_req_s r);
    is_builtin_out = (r.area == beo_pkg::AREA_IO) && (r.word >= beo_pkg::OUT_WORD_LO) &&
                     (r.word <= beo_pkg::OUT_WORD_HI);
  endfunction

  // stage 1 holds the request while its history word is read
  logic                        s1_valid_q;
  beo_pkg::beo_req_s           s1_req_q;
  logic                        fwd_hit_q;
  logic                        fwd_val_q;
  logic                        hist_rd;

  logic                        s1_edge;
  logic                        s1_bad;
  logic                        s1_eval;
  logic                        s1_cond_eff;
  logic                        s1_prev;
  logic                        s1_pulse;
  logic                        s1_hist_we;
  logic                        s1_latch_we;
  logic                        s1_edge_we;
  logic                        s1_we;
  logic                        s1_val;
  beo_pkg::beo_wr_s            s1_wr;

  beo_hist_mem u_hist (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .rd_addr_i (req_i.inst),
    .rd_data_o (hist_rd),
    .wr_en_i   (s1_hist_we),
    .wr_addr_i (s1_req_q.inst),
    .wr_data_i (s1_cond_eff)
  );

  // every request is taken, none merged with another
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s1_valid_q <= 1'b0;
    end else begin
      s1_valid_q <= req_valid_i; // RULE11
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s1_req_q <= '0;
    end else if (req_valid_i) begin
      s1_req_q <= req_i;
    end
  end

  // back-to-back evaluations of one instance would read a stale history word
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      fwd_hit_q <= 1'b0;
      fwd_val_q <= beo_pkg::HIST_RST;
    end else begin
      fwd_hit_q <= s1_hist_we && (s1_req_q.inst == req_i.inst); // RULE15
      fwd_val_q <= s1_cond_eff;
    end
  end

  always_comb begin
    s1_edge     = is_edge_op(s1_req_q.op);
    s1_bad      = is_tc_area(s1_req_q.area); // RULE10
    // a jumped section or an idle subroutine does not evaluate at all
    s1_eval     = !s1_req_q.jumped && !s1_req_q.sub_off; // RULE13
    // an interlocked section presents its edge instructions with an OFF condition
    s1_cond_eff = s1_req_q.cond && !s1_req_q.ilk_on; // RULE12
    s1_prev     = fwd_hit_q ? fwd_val_q : hist_rd; // RULE15
    if (s1_req_q.op == beo_pkg::OP_RISING_EDGE_PULSE) begin
      s1_pulse = s1_cond_eff && !s1_prev; // RULE1 RULE2
    end else begin
      s1_pulse = !s1_cond_eff && s1_prev; // RULE3 RULE4
    end
    s1_hist_we  = s1_valid_q && s1_edge && s1_eval && !s1_bad; // RULE15
    s1_edge_we  = s1_hist_we;
    s1_latch_we = s1_valid_q && !s1_edge && !s1_bad && s1_eval && s1_cond_eff; // RULE6 RULE7 RULE9
    s1_we       = s1_edge_we || s1_latch_we;
    if (s1_edge) begin
      s1_val = s1_pulse;
    end else begin
      s1_val = (s1_req_q.op == beo_pkg::OP_BIT_SET_LATCH); // RULE6 RULE7
    end
    s1_wr.area  = s1_req_q.area;
    s1_wr.word  = s1_req_q.word;
    s1_wr.bitn  = s1_req_q.bitn;
    s1_wr.val   = s1_val;
  end

  // the side effects leaving this unit are an operand bit write and, for immediate outputs, its physical output refresh
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wr_valid_o <= 1'b0;
      wr_o       <= '0;
    end else begin
      wr_valid_o <= s1_we; // RULE5
      wr_o       <= s1_wr;
    end
  end

  // the physical output follows in the same cycle as the memory write
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      refresh_valid_o <= 1'b0;
      refresh_o       <= '0;
    end else begin
      refresh_valid_o <= s1_we && s1_req_q.imm && is_builtin_out(s1_req_q); // RULE8
      refresh_o       <= s1_wr;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reject_o <= 1'b0;
    end else begin
      reject_o <= s1_valid_q && s1_bad; // RULE10
    end
  end

  // repeated evaluations of one instance in a scan are not checked; the forwarding above keeps back-to-back ones correct
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      skip_o <= 1'b0;
    end else begin
      skip_o <= s1_valid_q && !s1_bad && !s1_eval; // RULE13
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_rise_edge;
    s1_valid_q && s1_req_q.op == beo_pkg::OP_RISING_EDGE_PULSE && s1_eval && !s1_bad && s1_cond_eff && !s1_prev;
  endsequence

  sequence s_fall_edge;
    s1_valid_q && s1_req_q.op == beo_pkg::OP_FALLING_EDGE_PULSE && s1_eval && !s1_bad && !s1_cond_eff && s1_prev;
  endsequence

  sequence s_edge_eval_on;
    s1_hist_we && s1_cond_eff;
  endsequence

  sequence s_edge_eval_off;
    s1_hist_we && !s1_cond_eff;
  endsequence

  sequence s_latch_go;
    req_valid_i && !is_edge_op(req_i.op) && req_i.cond && !req_i.ilk_on && !req_i.jumped && !req_i.sub_off &&
    !is_tc_area(req_i.area);
  endsequence

  a_rise_pulse_on : assert property ( // RULE1
    s_rise_edge |=> wr_valid_o && wr_o.val)
    else $error("rising edge did not write operand on");

  // two back-to-back evaluations of one instance: second one clears
  a_rise_pulse_off : assert property ( // RULE2
    s_rise_edge ##1 (s1_valid_q && s1_req_q.op == beo_pkg::OP_RISING_EDGE_PULSE && s1_eval && !s1_bad &&
                     s1_req_q.inst == $past(s1_req_q.inst) && s1_cond_eff) |=> wr_valid_o && !wr_o.val)
    else $error("rising pulse lasted more than one evaluation");

  a_fall_pulse_on : assert property ( // RULE3
    s_fall_edge |=> wr_valid_o && wr_o.val)
    else $error("falling edge did not write operand on");

  a_fall_pulse_off : assert property ( // RULE4
    s_fall_edge ##1 (s1_valid_q && s1_req_q.op == beo_pkg::OP_FALLING_EDGE_PULSE && s1_eval && !s1_bad &&
                     s1_req_q.inst == $past(s1_req_q.inst) && !s1_cond_eff) |=> wr_valid_o && !wr_o.val)
    else $error("falling pulse lasted more than one evaluation");

  a_set_forces_one : assert property ( // RULE6
    req_valid_i && req_i.op == beo_pkg::OP_BIT_SET_LATCH && req_i.cond && !req_i.ilk_on && !req_i.jumped &&
    !req_i.sub_off && !is_tc_area(req_i.area) |-> ##2 wr_valid_o && wr_o.val && wr_o.word == $past(req_i.word, 2))
    else $error("set with condition on did not write one");

  a_clear_forces_zero : assert property ( // RULE7
    req_valid_i && req_i.op == beo_pkg::OP_BIT_CLEAR_LATCH && req_i.cond && !req_i.ilk_on && !req_i.jumped &&
    !req_i.sub_off && !is_tc_area(req_i.area) |-> ##2 wr_valid_o && !wr_o.val)
    else $error("clear with condition on did not write zero");

  a_latch_hold : assert property ( // RULE9
    req_valid_i && !is_edge_op(req_i.op) && (req_i.ilk_on || req_i.jumped || !req_i.cond) |-> ##2 !wr_valid_o)
    else $error("latch changed operand while held");

  a_tc_refused : assert property ( // RULE10
    req_valid_i && is_tc_area(req_i.area) |-> ##2 (reject_o && !wr_valid_o))
    else $error("timer or counter operand was not refused");

  a_refresh_match : assert property ( // RULE8
    refresh_valid_o |-> wr_valid_o && refresh_o == wr_o && $past(s1_req_q.imm))
    else $error("refresh without matching operand write");

  a_sub_skip : assert property ( // RULE13
    req_valid_i && is_edge_op(req_i.op) && req_i.sub_off && !is_tc_area(req_i.area) |-> ##2 (skip_o && !wr_valid_o))
    else $error("edge in idle subroutine was evaluated");

  a_rise_off_quiet : assert property ( // RULE1
    s_edge_eval_off ##0 (s1_req_q.op == beo_pkg::OP_RISING_EDGE_PULSE)
    |=> wr_valid_o && !wr_o.val)
    else $error("rising edge wrote on while its condition was off");

  a_fall_on_quiet : assert property ( // RULE3
    s_edge_eval_on ##0 (s1_req_q.op == beo_pkg::OP_FALLING_EDGE_PULSE)
    |=> wr_valid_o && !wr_o.val)
    else $error("falling edge wrote on while its condition was on");

  a_edge_writes : assert property ( // RULE12
    req_valid_i && is_edge_op(req_i.op) && !is_tc_area(req_i.area) && !req_i.jumped && !req_i.sub_off
    |-> ##2 wr_valid_o)
    else $error("evaluated edge instruction wrote nothing");

  a_ilk_rise_quiet : assert property ( // RULE12
    req_valid_i && req_i.op == beo_pkg::OP_RISING_EDGE_PULSE && req_i.ilk_on && !is_tc_area(req_i.area) &&
    !req_i.jumped && !req_i.sub_off |-> ##2 (wr_valid_o && !wr_o.val))
    else $error("interlocked rising edge wrote on");

  a_jump_skip : assert property ( // RULE9
    req_valid_i && req_i.jumped && !is_tc_area(req_i.area)
    |-> ##2 (skip_o && !wr_valid_o))
    else $error("jumped instruction was evaluated");

  a_tc_quiet : assert property ( // RULE10
    req_valid_i && is_tc_area(req_i.area)
    |-> ##2 (!skip_o && !refresh_valid_o))
    else $error("timer or counter operand was skipped or refreshed");

  a_one_outcome : assert property ( // RULE5
    $onehot0({wr_valid_o, reject_o, skip_o}))
    else $error("more than one outcome for one request");

  a_idle_quiet : assert property ( // RULE5
    !req_valid_i
    |-> ##2 (!wr_valid_o && !reject_o && !skip_o))
    else $error("outcome without a request");

  a_wr_target : assert property ( // RULE11
    req_valid_i
    |-> ##2 (!wr_valid_o || (wr_o.area == $past(req_i.area, 2) && wr_o.word == $past(req_i.word, 2) &&
                             wr_o.bitn == $past(req_i.bitn, 2))))
    else $error("write landed on another operand");

  a_latch_repeat : assert property ( // RULE11
    s_latch_go ##1 s_latch_go |-> ##2 wr_valid_o)
    else $error("back to back latch request was lost");

  a_refresh_builtin : assert property ( // RULE8
    refresh_valid_o
    |-> (refresh_o.area == beo_pkg::AREA_IO && refresh_o.word >= beo_pkg::OUT_WORD_LO &&
         refresh_o.word <= beo_pkg::OUT_WORD_HI))
    else $error("refresh aimed at a non-output operand");

  a_refresh_imm : assert property ( // RULE8
    req_valid_i && req_i.imm && is_edge_op(req_i.op) && is_builtin_out(req_i) && !req_i.jumped && !req_i.sub_off
    |-> ##2 refresh_valid_o)
    else $error("immediate edge on an output was not refreshed");

  a_refresh_needs_imm : assert property ( // RULE8
    req_valid_i && !req_i.imm
    |-> ##2 !refresh_valid_o)
    else $error("refresh without the immediate variant");

  a_refused_quiet : assert property ( // RULE5
    (skip_o || reject_o)
    |-> (!wr_valid_o && !refresh_valid_o))
    else $error("refused request still changed an operand");

endmodule

// *** testbench/beo_exec_bench.sv ***
// self-checking bench for the bit edge and latch execution unit
`timescale 1ns/1ps
module beo_exec_bench;
  typedef struct packed {
    logic              v;
    beo_pkg::beo_req_s r;
    logic [4:0]        e;
  } beo_row_s;
  // e holds write, value, refresh, reject, skip
  localparam logic [3:0] RISE = beo_pkg::OP_RISING_EDGE_PULSE;
  localparam logic [3:0] FALL = beo_pkg::OP_FALLING_EDGE_PULSE;
  localparam logic [3:0] SETL = beo_pkg::OP_BIT_SET_LATCH;
  localparam logic [3:0] CLRL = beo_pkg::OP_BIT_CLEAR_LATCH;
  localparam logic [2:0] IO   = beo_pkg::AREA_IO;
  localparam logic [2:0] WRK  = beo_pkg::AREA_WORK;
  localparam logic [2:0] TMR  = beo_pkg::AREA_TIMER;
  localparam logic [2:0] CNT  = beo_pkg::AREA_COUNTER;
  logic              sys_clk_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic              req_valid_i = 1'b0;
  beo_pkg::beo_req_s req_i = '0;
  logic              wr_valid_o;
  beo_pkg::beo_wr_s  wr_o;
  logic              refresh_valid_o;
  beo_pkg::beo_wr_s  refresh_o;
  logic              reject_o;
  logic              skip_o;
  logic              hist [64];
  beo_row_s          rows [$];
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                n0;

  always #20 sys_clk_i = ~sys_clk_i;

  beo_exec dut_u (
    .sys_clk_i       (sys_clk_i),
    .rst_b_i         (rst_b_i),
    .req_valid_i     (req_valid_i),
    .req_i           (req_i),
    .wr_valid_o      (wr_valid_o),
    .wr_o            (wr_o),
    .refresh_valid_o (refresh_valid_o),
    .refresh_o       (refresh_o),
    .reject_o        (reject_o),
    .skip_o          (skip_o)
  );

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // reference model: expectation fixed when the row is queued, so rows must be queued in issue order
  task automatic add(input logic [3:0] op, input logic imm, input logic [2:0] ar, input logic [7:0] wd,
                     input logic [5:0] in, input logic [3:0] fl);
    beo_row_s x;
    logic     c;
    logic     p;
    x = '0;
    x.v = 1'b1;
    x.r.op = beo_pkg::beo_op_e'(op);
    x.r.imm = imm;
    x.r.area = beo_pkg::beo_area_e'(ar);
    x.r.word = wd;
    x.r.bitn = in[3:0];
    x.r.inst = in;
    {x.r.cond, x.r.ilk_on, x.r.jumped, x.r.sub_off} = fl;
    c = fl[3] & ~fl[2];
    if (ar == TMR || ar == CNT) begin
      x.e[1] = 1'b1;
    end else if (fl[1] | fl[0]) begin
      x.e[0] = 1'b1;
    end else if (op[1:0] != 2'b00) begin
      p = hist[in];
      hist[in] = c;
      x.e[4] = 1'b1;
      x.e[3] = op[0] ? (c & ~p) : (~c & p);
    end else if (c) begin
      x.e[4] = 1'b1;
      x.e[3] = op[2];
    end
    x.e[2] = x.e[4] & imm & (ar == IO) & (wd >= beo_pkg::OUT_WORD_LO) & (wd <= beo_pkg::OUT_WORD_HI);
    rows.push_back(x);
  endtask

  // streams rows back to back; answers land two edges after the driving edge
  task automatic run(input int lo, input int hi);
    beo_row_s         y;
    beo_pkg::beo_wr_s w;
    for (int i = lo; i <= hi + 2; i++) begin
      @(posedge sys_clk_i);
      req_valid_i <= (i <= hi) ? rows[i].v : 1'b0;
      req_i <= (i <= hi) ? rows[i].r : '0;
      @(negedge sys_clk_i);
      if (i >= lo + 2) begin
        y = rows[i-2];
        w = '{y.r.area, y.r.word, y.r.bitn, y.e[3]};
        chk("strobes", {12'h000, y.e[4], y.e[2], y.e[1], y.e[0]},
            {12'h000, wr_valid_o, refresh_valid_o, reject_o, skip_o});
        if (y.e[4]) chk("wr_o", w, wr_o);
        if (y.e[2]) chk("refresh_o", w, refresh_o);
      end
    end
  endtask

  task automatic do_reset(input int n);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    req_valid_i <= 1'b0;
    repeat (n - 1) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("outputs in reset", 16'h0000, {12'h000, wr_valid_o, refresh_valid_o, reject_o, skip_o});
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    foreach (hist[k]) hist[k] = 1'b0;
  endtask

  initial begin
    #(40 * 400);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    do_reset(6);
    add(RISE, 1'b1, IO, 8'h64, 6'h03, 4'h8);
    add(RISE, 1'b1, IO, 8'h64, 6'h03, 4'h8);
    add(RISE, 1'b0, IO, 8'h64, 6'h03, 4'h0);
    add(FALL, 1'b0, WRK, 8'h20, 6'h05, 4'h8);
    add(FALL, 1'b1, IO, 8'h65, 6'h05, 4'h0);
    add(FALL, 1'b1, IO, 8'h65, 6'h05, 4'h0);
    add(RISE, 1'b0, WRK, 8'h21, 6'h07, 4'h9);
    add(RISE, 1'b0, WRK, 8'h21, 6'h07, 4'h8);
    add(RISE, 1'b0, WRK, 8'h21, 6'h07, 4'hC);
    add(RISE, 1'b0, WRK, 8'h21, 6'h07, 4'h8);
    add(FALL, 1'b0, WRK, 8'h22, 6'h09, 4'hA);
    add(FALL, 1'b0, WRK, 8'h23, 6'h0B, 4'h8);
    add(FALL, 1'b0, WRK, 8'h23, 6'h0B, 4'hC);
    rows.push_back('0);
    add(SETL, 1'b1, IO, 8'h64, 6'h01, 4'h8);
    add(CLRL, 1'b1, IO, 8'h64, 6'h01, 4'h8);
    add(SETL, 1'b0, WRK, 8'h30, 6'h02, 4'h0);
    add(CLRL, 1'b0, WRK, 8'h30, 6'h02, 4'h0);
    add(SETL, 1'b0, WRK, 8'h30, 6'h02, 4'hC);
    add(CLRL, 1'b0, WRK, 8'h30, 6'h02, 4'hA);
    add(SETL, 1'b1, IO, 8'h64, 6'h02, 4'h9);
    add(SETL, 1'b0, TMR, 8'h01, 6'h02, 4'h8);
    add(CLRL, 1'b0, CNT, 8'h01, 6'h02, 4'h8);
    add(RISE, 1'b0, TMR, 8'h01, 6'h03, 4'h8);
    add(RISE, 1'b0, IO, 8'hFF, 6'h03, 4'h8);
    add(SETL, 1'b1, WRK, 8'h64, 6'h04, 4'h8);
    add(SETL, 1'b1, IO, 8'h63, 6'h04, 4'h8);
    run(0, rows.size() - 1);
    n0 = rows.size();
    add(RISE, 1'b0, WRK, 8'h40, 6'h0A, 4'h8);
    run(n0, n0);
    do_reset(2);
    n0 = rows.size();
    add(RISE, 1'b0, WRK, 8'h40, 6'h0A, 4'h8);
    run(n0, n0);
    report_and_stop();
  end
endmodule
